// file: design/papr_cfg.svh
/*
 * Offsets, codes, field positions and reset values of the power,
 * activation and auto-configuration registers.
 * Assumes inclusion by the package, the register bank and the bench.
 */
`ifndef PAPR_CFG_SVH
`define PAPR_CFG_SVH

// ==========================================================
// First group, page 3 offsets
`define PAPR_OFF_CFG3 4'h6
`define PAPR_OFF_CSNB 4'h8
`define PAPR_OFF_HALT 4'h9
`define PAPR_OFF_IRQ 4'hB
`define PAPR_OFF_FWG 4'hC
`define PAPR_OFF_CFG4 4'hD
`define PAPR_G1_BASE 6'h30
// ==========================================================
// Field positions
`define PAPR_BIT_POWER_DOWN_BIT 1
`define PAPR_BIT_INACT 0
`define PAPR_BIT_FDEC 0
// ==========================================================
// Written codes
`define PAPR_HALT_RUN 8'h52
`define PAPR_HALT_STOP 8'h48
`define PAPR_FWG_KEY1 8'h57
`define PAPR_FWG_KEY2 8'hA8
// ==========================================================
// Auto-configuration ports and indexes
`define PAPR_PORT_ADDR 12'h279
`define PAPR_PORT_WDATA 12'hA79
`define PAPR_IDX_RDPORT 8'h00
`define PAPR_IDX_CSN 8'h06
`define PAPR_IDX_ACT 8'h30
`define PAPR_IDX_CSNB 8'hF5
// ==========================================================
// Reset values
`define PAPR_RST_RDPORT 8'h00
`define PAPR_RST_BYTE 8'h00

`endif

// file: design/papr_pkg.sv
/*
 * Types of the power, activation and auto-configuration registers.
 * Assumes papr_cfg.svh is on the include path.
 */
package papr_pkg;
  `include "papr_cfg.svh"

  // ==========================================================
  // Power-down variant held after a clock-halt write
  typedef enum logic [0:0] {
    PAPR_MODE_RUN = 1'b0,
    PAPR_MODE_HALT = 1'b1
  } papr_mode_t;

  // Progress through the flash unlock bytes
  typedef enum logic [1:0] {
    PAPR_FW_IDLE = 2'b00,
    PAPR_FW_KEY1 = 2'b01,
    PAPR_FW_OPEN = 2'b10
  } papr_fw_t;

  typedef logic [7:0] papr_byte_t;
endpackage

// file: design/papr_regs.sv
/*
 * Power, activation, address-decode and auto-configuration
 * register bank of the network controller, reached by host I/O
 * cycles. Assumes asynchronous host strobes held stable for at
 * least four clk_sys cycles, and a first-group page 3 select
 * from the surrounding command logic on clk_sys.
 */
`include "papr_cfg.svh"

// Summary of operation
// - Power-down bit enters power-down; clock-halt picks run or halt.
// - In power-down the network interface and transceiver are off.
// - In power-down LEDs are forced high, the coax LED low.
// - Halted mode stops the core clock; of the first group only clock-halt stays reachable.
// - Power-down bit loads from EEPROM; writes need both mode bits set.
// - Inactive flag reads as inverse of activate register bit 0.
// - Deactivated: boot ROM reads and first group, bar clock-halt, ignored.
// - Deactivated: clock-halt register and plug-and-play logic keep working.
// - Full-decode set makes the first group decode address lines 15..0, else 9..0.
// - Full-decode bit is read-only, loaded from EEPROM configuration byte.
// - Read-only register at offset 08H holds the card select backup.
// - Clock-halt writes ignored unless power-down bit is set.
// - Clock-halt write 52H runs clock, 48H halts, others ignored.
// - Interrupt state register returns levels of the eight request pins.
// - Flash guard writes accepted only with both EEPROM mode bits set.
// - Writing 57H then A8H enables flash writes; other data disables.
// - Flash write commands are discarded unless unlocked.
// - Address, write-data and relocatable read-data ports are provided.
// - One index write serves any number of following data accesses.
// - Address port writes are passed on for initiation key checking.
// - Undefined plug-and-play registers read as zero.
// - Index 00H sets read port address bits 9..2; bits 1..0 are one.
// - Card select writes also update the backup register.
module papr_regs
  import papr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host I/O cycle pins
  input wire logic [15:0] sa,
  input wire logic [7:0] sd_in,
  input wire logic iow_n,
  input wire logic ior_n,
  output papr_pkg::papr_byte_t sd_out,
  output logic sd_oe,
  // Page select and EEPROM state
  input wire logic pg3_sel,
  input wire logic [1:0] eem,
  input wire logic ee_power_down_bit,
  input wire logic ee_full_dec,
  // Interrupt pins, LEDs, power control
  input wire logic [7:0] irq_request_pins,
  input wire logic [2:0] led_in,
  input wire logic coax_led_in,
  output logic [2:0] led_out,
  output logic coax_led_output,
  output logic net_off,
  output logic core_clk_en,
  // Boot ROM and flash gating
  input wire logic rom_rd_req,
  output logic rom_rd_ok,
  input wire logic flash_wr_req,
  output logic flash_wr_ok,
  // Plug-and-play side
  output logic key_stb,
  output papr_pkg::papr_byte_t key_data,
  output papr_pkg::papr_byte_t pnp_index,
  output papr_pkg::papr_byte_t csn_out,
  output logic active
);
  import papr_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [15:0] sa_s1_r, sa_s2_r;
  logic [7:0] sd_s1_r, sd_s2_r, irq_s1_r, irq_s2_r;
  logic [1:0] wr_s_r, rd_s_r;
  logic wr_d_r, rd_d_r;

  // Two stages for every host pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sa_s1_r <= 16'h0000;
      sa_s2_r <= 16'h0000;
      sd_s1_r <= 8'h00;
      sd_s2_r <= 8'h00;
      irq_s1_r <= 8'h00;
      irq_s2_r <= 8'h00;
      wr_s_r <= 2'h3;
      rd_s_r <= 2'h3;
      wr_d_r <= 1'b1;
      rd_d_r <= 1'b1;
    end else begin
      sa_s1_r <= sa;
      sa_s2_r <= sa_s1_r;
      sd_s1_r <= sd_in;
      sd_s2_r <= sd_s1_r;
      irq_s1_r <= irq_request_pins;
      irq_s2_r <= irq_s1_r;
      wr_s_r <= {wr_s_r[0], iow_n};
      rd_s_r <= {rd_s_r[0], ior_n};
      wr_d_r <= wr_s_r[1];
      rd_d_r <= rd_s_r[1];
    end
  end

  logic wr_go, rd_go;
  assign wr_go = wr_d_r & ~wr_s_r[1];
  assign rd_go = rd_d_r & ~rd_s_r[1];

  // ==========================================================
  // State registers
  logic power_down_bit_r, fdec_r, ld_pend_r, act_r;
  papr_mode_t mode_r;
  papr_fw_t fw_r;
  papr_byte_t rdport_r, csn_r, csnb_r, idx_r;

  // ==========================================================
  // Address decode
  logic hi_ok, g1_hit, g1_open, halt_hit;
  logic p_addr, p_wdat, p_rdat;
  logic [3:0] off;
  assign off = sa_s2_r[3:0];
  assign hi_ok = ~fdec_r | (sa_s2_r[15:10] == 6'h00);
  assign g1_hit = hi_ok & pg3_sel
    & (sa_s2_r[9:4] == `PAPR_G1_BASE);
  // Deactivated or halted: only clock-halt stays reachable
  assign g1_open = act_r & ~(power_down_bit_r & mode_r == PAPR_MODE_HALT);
  assign halt_hit = g1_hit & (off == `PAPR_OFF_HALT);
  assign p_addr = sa_s2_r[11:0] == `PAPR_PORT_ADDR;
  assign p_wdat = sa_s2_r[11:0] == `PAPR_PORT_WDATA;
  assign p_rdat = (sa_s2_r[15:10] == 6'h00)
    & (sa_s2_r[9:0] == {rdport_r, 2'b11});

  logic g1_wr, g1_rd, eem_ok;
  assign g1_wr = wr_go & g1_hit & g1_open;
  assign g1_rd = rd_go & g1_hit & g1_open;
  assign eem_ok = eem == 2'b11;

  // ==========================================================
  // Power-down bit and full-decode bit, loaded after reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ld_pend_r <= 1'b1;
      power_down_bit_r <= 1'b0;
      fdec_r <= 1'b0;
    end else begin
      ld_pend_r <= 1'b0;
      if (ld_pend_r) begin
        power_down_bit_r <= ee_power_down_bit;
        fdec_r <= ee_full_dec;
      end else if (g1_wr && off == `PAPR_OFF_CFG3 && eem_ok) begin
        power_down_bit_r <= sd_s2_r[`PAPR_BIT_POWER_DOWN_BIT];
      end
    end
  end

  // Clock-halt variant select
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_r <= PAPR_MODE_RUN;
    end else if (wr_go && halt_hit && power_down_bit_r) begin
      if (sd_s2_r == `PAPR_HALT_RUN) begin
        mode_r <= PAPR_MODE_RUN;
      end else if (sd_s2_r == `PAPR_HALT_STOP) begin
        mode_r <= PAPR_MODE_HALT;
      end
    end
  end

  // Flash unlock sequence
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fw_r <= PAPR_FW_IDLE;
    end else if (g1_wr && off == `PAPR_OFF_FWG && eem_ok) begin
      case (fw_r)
        PAPR_FW_KEY1: begin
          fw_r <= (sd_s2_r == `PAPR_FWG_KEY2) ? PAPR_FW_OPEN
            : (sd_s2_r == `PAPR_FWG_KEY1) ? PAPR_FW_KEY1
            : PAPR_FW_IDLE;
        end
        default: begin
          fw_r <= (sd_s2_r == `PAPR_FWG_KEY1) ? PAPR_FW_KEY1
            : PAPR_FW_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Plug-and-play index and registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idx_r <= `PAPR_RST_BYTE;
    end else if (wr_go && p_addr) begin
      idx_r <= sd_s2_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdport_r <= `PAPR_RST_RDPORT;
      csn_r <= `PAPR_RST_BYTE;
      csnb_r <= `PAPR_RST_BYTE;
      act_r <= 1'b0;
    end else if (wr_go && p_wdat) begin
      case (idx_r)
        `PAPR_IDX_RDPORT: rdport_r <= sd_s2_r;
        `PAPR_IDX_CSN: begin
          csn_r <= sd_s2_r;
          csnb_r <= sd_s2_r;
        end
        `PAPR_IDX_ACT: act_r <= sd_s2_r[0];
        default: ;
      endcase
    end
  end

  // Address-port writes passed on for the key checker
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      key_stb <= 1'b0;
      key_data <= `PAPR_RST_BYTE;
    end else begin
      key_stb <= wr_go & p_addr;
      if (wr_go && p_addr) begin
        key_data <= sd_s2_r;
      end
    end
  end

  // ==========================================================
  // Read data and bus drive
  papr_byte_t rd_nxt;
  always_comb begin
    rd_nxt = 8'h00;
    if (p_rdat) begin
      case (idx_r)
        `PAPR_IDX_CSN: rd_nxt = csn_r;
        `PAPR_IDX_ACT: rd_nxt = {7'h00, act_r};
        `PAPR_IDX_CSNB: rd_nxt = csnb_r;
        default: rd_nxt = 8'h00;
      endcase
    end else begin
      case (off)
        `PAPR_OFF_CFG3: rd_nxt = {6'h00, power_down_bit_r, ~act_r};
        `PAPR_OFF_CSNB: rd_nxt = csnb_r;
        `PAPR_OFF_IRQ: rd_nxt = irq_s2_r;
        `PAPR_OFF_CFG4: rd_nxt = {7'h00, fdec_r};
        default: rd_nxt = 8'h00;
      endcase
    end
  end

  // Drive from read start until strobe release
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sd_out <= 8'h00;
      sd_oe <= 1'b0;
    end else if (rd_go && (p_rdat || g1_rd)) begin
      sd_out <= rd_nxt;
      sd_oe <= 1'b1;
    end else if (rd_s_r[1]) begin
      sd_oe <= 1'b0;
    end
  end

  // ==========================================================
  // Power-down effects and gating
  logic pd;
  assign pd = power_down_bit_r;
  assign net_off = pd;
  assign led_out = pd ? 3'h7 : led_in;
  assign coax_led_output = pd ? 1'b0 : coax_led_in;
  assign core_clk_en = ~(pd & mode_r == PAPR_MODE_HALT);
  assign rom_rd_ok = rom_rd_req & act_r;
  assign flash_wr_ok = flash_wr_req & (fw_r == PAPR_FW_OPEN);
  assign pnp_index = idx_r;
  assign csn_out = csn_r;
  assign active = act_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence fw_key1_s;
    g1_wr && off == `PAPR_OFF_FWG && eem_ok && sd_s2_r == 8'h57;
  endsequence
  sequence fw_key2_s;
    g1_wr && off == `PAPR_OFF_FWG && eem_ok && sd_s2_r == 8'hA8;
  endsequence

  // Second key byte right after the first opens the gate
  unlock_seq_a: assert property (
    (fw_r == PAPR_FW_KEY1) ##0 fw_key2_s
    |=> flash_wr_ok == flash_wr_req)
    else $error("unlock sequence did not open flash");
  key1_track_a: assert property (
    fw_key1_s |=> fw_r == PAPR_FW_KEY1)
    else $error("first key byte not tracked");
  flash_gate_a: assert property (
    fw_r != PAPR_FW_OPEN |-> !flash_wr_ok)
    else $error("flash write passed while locked");
  halt_ignore_a: assert property (
    !power_down_bit_r ##0 $stable(power_down_bit_r) |=> $stable(mode_r))
    else $error("clock-halt changed outside power-down");
  halt_stop_a: assert property (
    wr_go && halt_hit && power_down_bit_r && sd_s2_r == 8'h48
    |=> !core_clk_en)
    else $error("halt code did not stop core clock");
  pd_led_a: assert property (
    power_down_bit_r |-> led_out == 3'h7 && !coax_led_output && net_off)
    else $error("power-down outputs wrong");
  inact_rd_a: assert property (
    rd_go && g1_rd && off == 4'h6 |=> sd_out[0] == !$past(act_r))
    else $error("inactive flag not inverse of activate");
  csn_copy_a: assert property (
    wr_go && p_wdat && idx_r == 8'h06 |=> csnb_r == csn_r)
    else $error("card select backup not updated");
  deact_a: assert property (
    !act_r && rd_go && !p_rdat |=> !sd_oe)
    else $error("deactivated first group answered");
  index_keep_a: assert property (
    !(wr_go && p_addr) |=> $stable(idx_r))
    else $error("index changed without address write");
  undef_zero_a: assert property (
    rd_go && p_rdat && idx_r == 8'h07 |=> sd_out == 8'h00)
    else $error("undefined index read nonzero");
  // Mode bits gate power-down and flash guard writes
  power_down_bit_lock_a: assert property (
    g1_wr && off == `PAPR_OFF_CFG3 && !eem_ok && !ld_pend_r
    |=> $stable(power_down_bit_r))
    else $error("power-down bit written while locked");
  fw_guard_a: assert property (
    g1_wr && off == `PAPR_OFF_FWG && !eem_ok |=> $stable(fw_r))
    else $error("flash guard written while locked");
  irq_read_a: assert property (
    g1_rd && !p_rdat && off == `PAPR_OFF_IRQ
    |=> sd_out == $past(irq_s2_r))
    else $error("interrupt levels not returned");
  key_pass_a: assert property (
    wr_go && p_addr |=> key_stb && key_data == $past(sd_s2_r))
    else $error("address port write not passed on");
endmodule // papr_regs

// file: tb/papr_host_model.sv
/*
 * Host model issuing single-byte I/O write and read cycles.
 * Assumes clk_sys is the bench clock; write strobes are held for
 * strobe_len cycles and read strobes for strobe_len + 1 cycles,
 * which the bench may lengthen.
 */
module papr_host_model (
  // Clock
  input wire logic clk_sys,
  // Host I/O pins
  output logic [15:0] sa,
  output logic [7:0] sd_in,
  output logic iow_n,
  output logic ior_n,
  // Read answer
  input wire logic [7:0] sd_out,
  input wire logic sd_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  int strobe_len = 5;

  // ==========================================================
  // Idle bus at time zero
  initial begin
    sa = 16'h0000;
    sd_in = 8'h00;
    iow_n = 1'h1;
    ior_n = 1'h1;
  end

  // Write: setup 2, strobe low, recovery 4, then bus let go
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys) sa <= a;
    sd_in <= d;
    repeat (2) @(posedge clk_sys);
    iow_n <= 1'h0;
    repeat (strobe_len) @(posedge clk_sys);
    iow_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
    sa <= ~a;
    sd_in <= ~d; // Released lines show a changed value
  endtask

  // Read: answer taken at the edge before the strobe rises
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d,
                       output logic oe);
    @(posedge clk_sys) sa <= a;
    repeat (2) @(posedge clk_sys);
    ior_n <= 1'h0;
    repeat (strobe_len + 1) @(posedge clk_sys);
    d = sd_out;
    oe = sd_oe;
    ior_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
    sa <= ~a;
  endtask
endmodule // papr_host_model

// file: tb/tb.sv
/*
 * Self-checking bench of the power, activation and
 * auto-configuration register bank. Assumes papr_pkg, the
 * header on the include path and the host model.
 */
`include "papr_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import papr_pkg::*;
  logic clk_sys, rst, iow_n, ior_n, sd_oe, pg3_sel, ee_power_down_bit;
  logic ee_full_dec, coax_led_in, coax_led_output, net_off;
  logic core_clk_en, rom_rd_req, rom_rd_ok, flash_wr_req;
  logic flash_wr_ok, key_stb, active;
  logic [15:0] sa;
  logic [7:0] sd_in, irq_request_pins;
  logic [2:0] led_in, led_out;
  logic [1:0] eem;
  papr_byte_t sd_out, key_data, pnp_index, csn_out;
  int fails, compares, key_cnt, key_exp;
  logic [23:0] fseq [4] = '{24'h57A833, 24'h5757A8, 24'h5711A8,
                            24'h1157A8};
  logic [3:0] fexp = 4'hA;
  localparam logic [15:0] rp_addr = {6'h00, 8'h80, 2'h3};

  // ==========================================================
  // Design, host and clock
  papr_regs u_dut (.clk_sys, .rst, .sa, .sd_in, .iow_n, .ior_n,
    .sd_out, .sd_oe, .pg3_sel, .eem, .ee_power_down_bit, .ee_full_dec,
    .irq_request_pins, .led_in, .coax_led_in, .led_out,
    .coax_led_output, .net_off, .core_clk_en, .rom_rd_req,
    .rom_rd_ok, .flash_wr_req, .flash_wr_ok, .key_stb, .key_data,
    .pnp_index, .csn_out, .active);
  papr_host_model u_host (.clk_sys, .sa, .sd_in, .iow_n, .ior_n,
    .sd_out, .sd_oe);
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Count initiation key strobes
  always @(posedge clk_sys) begin
    if (key_stb === 1'h1) key_cnt++;
  end

  // ==========================================================
  // Compare, access and closing tasks
  task automatic chk8(input string n, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s exp %b got %b", n, e, g);
    end
  endtask
  function automatic logic [15:0] g1(input logic [3:0] o);
    return {6'h00, `PAPR_G1_BASE, o};
  endfunction
  task automatic g1w(input logic [3:0] o, input logic [7:0] v);
    u_host.io_wr(g1(o), v);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e,
                     input logic eo, input string n);
    logic [7:0] d;
    logic o;
    u_host.io_rd(a, d, o);
    chk1(n, eo, o);
    if (eo) chk8(n, e, d);
  endtask
  // Index first, data afterwards
  task automatic pidx(input logic [7:0] v);
    u_host.io_wr({4'h0, `PAPR_PORT_ADDR}, v);
    key_exp++;
    chk8("key_data", v, key_data);
    chk8("pnp_index", v, pnp_index);
  endtask
  task automatic pwr(input logic [7:0] v);
    u_host.io_wr({4'h0, `PAPR_PORT_WDATA}, v);
  endtask
  task automatic final_report();
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    final_report();
  end

  // Main sequence
  initial begin
    {fails, compares, key_cnt, key_exp} = '0;
    {rst, pg3_sel, rom_rd_req, flash_wr_req, coax_led_in} = 5'h1F;
    {eem, ee_power_down_bit, ee_full_dec} = 4'h1;
    irq_request_pins = 8'hA5;
    led_in = 3'h2;
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (3) @(posedge clk_sys);
    // Inactive after reset
    chk1("rom_rd_ok", 1'h0, rom_rd_ok);
    rdc(g1(`PAPR_OFF_CFG4), 8'h00, 1'h0, "cfg4 idle");
    pidx(`PAPR_IDX_ACT);
    pwr(8'h01);
    chk1("rom_rd_ok", 1'h1, rom_rd_ok);
    rdc(g1(`PAPR_OFF_CFG3), 8'h00, 1'h1, "cfg3");
    rdc(g1(`PAPR_OFF_CFG4), 8'h01, 1'h1, "cfg4");
    rdc(16'h1000 | g1(`PAPR_OFF_CFG4), 8'h01, 1'h0, "sa12");
    rdc(g1(`PAPR_OFF_IRQ), 8'hA5, 1'h1, "irq");
    @(posedge clk_sys) irq_request_pins <= 8'h3C;
    u_host.strobe_len = 8;
    rdc(g1(`PAPR_OFF_IRQ), 8'h3C, 1'h1, "irq slow");
    u_host.strobe_len = 5;
    // Card select, backup copy and relocated read port
    pidx(`PAPR_IDX_RDPORT);
    pwr(8'h80);
    pidx(`PAPR_IDX_CSN);
    pwr(8'h5A);
    chk8("csn_out", 8'h5A, csn_out);
    rdc(g1(`PAPR_OFF_CSNB), 8'h5A, 1'h1, "csn_backup");
    pidx(`PAPR_IDX_CSNB);
    rdc(rp_addr, 8'h5A, 1'h1, "pnp csnb");
    rdc(rp_addr, 8'h5A, 1'h1, "pnp again");
    rdc(rp_addr & 16'hFFFE, 8'h00, 1'h0, "rd port b0");
    pidx(8'h20);
    rdc(rp_addr, 8'h00, 1'h1, "undefined");
    pidx(8'h07);
    rdc(rp_addr, 8'h00, 1'h1, "log dev");
    // Power-down entry and clock-halt variants
    g1w(`PAPR_OFF_HALT, `PAPR_HALT_STOP);
    chk1("clk_en", 1'h1, core_clk_en);
    g1w(`PAPR_OFF_CFG3, 8'h02);
    chk1("net_off", 1'h0, net_off);
    @(posedge clk_sys) eem <= 2'h3;
    g1w(`PAPR_OFF_CFG3, 8'h02);
    chk1("net_off", 1'h1, net_off);
    chk8("led_out", 8'h07, {5'h00, led_out});
    chk1("coax_led", 1'h0, coax_led_output);
    chk1("clk_en", 1'h1, core_clk_en);
    g1w(`PAPR_OFF_HALT, 8'h11);
    chk1("clk_en", 1'h1, core_clk_en);
    g1w(`PAPR_OFF_HALT, `PAPR_HALT_STOP);
    chk1("clk_en", 1'h0, core_clk_en);
    rdc(g1(`PAPR_OFF_IRQ), 8'h00, 1'h0, "irq halted");
    pidx(`PAPR_IDX_ACT);
    pwr(8'h00);
    chk1("active", 1'h0, active);
    g1w(`PAPR_OFF_HALT, `PAPR_HALT_RUN);
    chk1("clk_en", 1'h1, core_clk_en);
    rdc(g1(`PAPR_OFF_CFG3), 8'h00, 1'h0, "cfg3 idle");
    pidx(`PAPR_IDX_ACT);
    pwr(8'h01);
    rdc(g1(`PAPR_OFF_CFG3), 8'h02, 1'h1, "cfg3 pd");
    g1w(`PAPR_OFF_CFG3, 8'h00);
    chk1("net_off", 1'h0, net_off);
    chk8("led_out", 8'h02, {5'h00, led_out});
    chk1("coax_led", 1'h1, coax_led_output);
    // Flash unlock sequences
    @(posedge clk_sys) eem <= 2'h0;
    g1w(`PAPR_OFF_FWG, `PAPR_FWG_KEY1);
    g1w(`PAPR_OFF_FWG, `PAPR_FWG_KEY2);
    chk1("flash_ok", 1'h0, flash_wr_ok);
    @(posedge clk_sys) eem <= 2'h3;
    for (int i = 0; i < 4; i++) begin
      for (int k = 2; k >= 0; k--) g1w(`PAPR_OFF_FWG, fseq[i][k*8+:8]);
      chk1("flash_ok", fexp[i], flash_wr_ok);
    end
    chk8("key count", key_exp[7:0], key_cnt[7:0]);
    // Reset in mid-run drops the unlock, new EEPROM defaults load
    @(posedge clk_sys) rst <= 1'h1;
    {ee_power_down_bit, ee_full_dec} <= 2'h2;
    repeat (5) @(posedge clk_sys);
    chk1("flash_ok", 1'h0, flash_wr_ok);
    rst <= 1'h0;
    repeat (3) @(posedge clk_sys);
    chk1("flash_ok", 1'h0, flash_wr_ok);
    // Short decode: clock-halt reachable while inactive, high lines set
    chk1("net_off", 1'h1, net_off);
    u_host.io_wr(16'hFC00 | g1(`PAPR_OFF_HALT), `PAPR_HALT_STOP);
    chk1("clk_en", 1'h0, core_clk_en);
    final_report();
  end
endmodule // tb
